//--- rtl/ldds_pkg.sv
/*
 * Shared constants and types of the loop detector diagnostic and
 * synchronisation block: register offsets, field positions, reset values,
 * alignment cause codes, sync roles and timing counts.
 * Assumes a 100 MHz system clock.
 */
package ldds_pkg;

    // ************************************************************
    // Register offsets (word index on the plain register port)
    // ************************************************************
    localparam logic [5:0] A_CTRL    = 6'h00;
    localparam logic [5:0] A_CMD     = 6'h01;
    localparam logic [5:0] A_STATUS  = 6'h02;
    localparam logic [5:0] A_RSTCAU  = 6'h03;
    localparam logic [5:0] A_RSTCNT  = 6'h04;
    localparam logic [5:0] A_CYCLE   = 6'h05;
    localparam logic [5:0] A_ADDRINF = 6'h06;
    localparam logic [5:0] A_THRESH  = 6'h08;
    localparam logic [5:0] A_ALIGN   = 6'h0C;
    localparam logic [5:0] A_HOLD    = 6'h10;
    localparam logic [5:0] A_PEAK    = 6'h14;
    localparam logic [5:0] A_CAUSE   = 6'h18;
    localparam logic [5:0] A_INDUCT  = 6'h1C;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int         CTRL_ROLE_BIT  = 0;
    localparam int         CTRL_HINF_BIT  = 1;
    localparam int         CMD_CLR_BIT    = 0;
    localparam int         CMD_ALIGN_BIT  = 1;
    localparam logic       RST_HOLD_INF   = 1'b1;
    localparam logic       RST_LED        = 1'b1;
    localparam logic [15:0] CNT_MAX       = 16'hFFFF;
    localparam logic [15:0] INDUCT_STEP   = 16'h000A;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int BLINK_HALF_NS  = 1000000000;
    localparam int SILENCE_NS     = 20000000;
    localparam int RESTART_NS     = 1000000;
    localparam int RESTART_DET_NS = 500000;
    localparam int MS_NS          = 1000000;
    localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
    localparam int SILENCE_CYC    = SILENCE_NS / CLK_PERIOD_NS;
    localparam int RESTART_CYC    = RESTART_NS / CLK_PERIOD_NS;
    localparam int RESTART_DET_CYC =
        (RESTART_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_CYC         = MS_NS / CLK_PERIOD_NS;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        C_OVERRANGE = 3'h0,
        C_NORM      = 3'h1,
        C_PARTNER   = 3'h2,
        C_HOLD      = 3'h3,
        C_USER      = 3'h4,
        C_SYNC      = 3'h5,
        C_MUTUAL    = 3'h6
    } ldds_cause_e;

    typedef enum logic [1:0] {
        SY_SLAVE  = 2'h0,
        SY_MASTER = 2'h1
    } ldds_sync_e;

endpackage : ldds_pkg

//--- rtl/ldds_top.sv
/*
 * Diagnostic and synchronisation logic of a four-channel loop detector.
 * Assumes all inputs synchronous to CLOCK, a measurement engine that takes
 * MEAS_START/MEAS_CH and answers MEAS_DONE, and an open-drain sync line
 * whose wired level returns on SYNC_I.
 */
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ns

module ldds_top #(
    parameter int BLINK_HALF = ldds_pkg::BLINK_HALF_CYC,
    parameter int SILENCE    = ldds_pkg::SILENCE_CYC,
    parameter int RESTART    = ldds_pkg::RESTART_CYC,
    parameter int RESTART_DET = ldds_pkg::RESTART_DET_CYC,
    parameter int MS_TICKS   = ldds_pkg::MS_CYC
) (
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic [5:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    output logic      [1:0]  RPAR,
    input  wire logic [63:0] DETUNE,
    input  wire logic [63:0] INDUCT,
    input  wire logic [3:0]  FAULT,
    input  wire logic [3:0]  OVERRANGE,
    input  wire logic [3:0]  NORM_BAD,
    input  wire logic [3:0]  HOLD_EV,
    input  wire logic [3:0]  STUCK,
    input  wire logic        RST_EVENT,
    input  wire logic [7:0]  RST_CAUSE,
    input  wire logic [3:0]  DIP_SW,
    input  wire logic        MEAS_DONE,
    output logic             MEAS_START,
    output logic      [1:0]  MEAS_CH,
    input  wire logic        SYNC_I,
    output logic             SYNC_O,
    output logic             SYNC_OE,
    output logic      [3:0]  OCC_OUT,
    output logic      [3:0]  ALIGN_REQ,
    output logic             LED_FUNC,
    output logic             TERM_EN
);
    import ldds_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic                   role;
        logic                   hold_inf;
        logic [3:0][15:0]       thresh;
        logic [3:0]             occ;
        logic [3:0]             fault;
        logic [3:0]             hist;
        logic [3:0]             align;
        ldds_cause_e [3:0]      cause;
        logic [3:0][15:0]       align_cnt;
        logic [3:0][15:0]       hold_cnt;
        logic [3:0][15:0]       peak;
        logic [7:0]             rst_cause;
        logic [15:0]            rst_cnt;
        logic [15:0]            rdata;
        logic [1:0]             rpar;
        logic [3:0]             dip;
        logic                   dip_done;
        ldds_sync_e             sy;
        logic                   synced;
        logic                   sync_prev;
        logic                   sync_oe;
        logic [31:0]            restart;
        logic [31:0]            low_cnt;
        logic [31:0]            silence;
        logic [31:0]            pre;
        logic [31:0]            blink;
        logic [15:0]            ms;
        logic [15:0]            cycle_ms;
        logic [1:0]             ch;
        logic                   busy;
        logic                   sync_meas;
        logic                   meas_start;
        logic                   led;
    } ldds_state_s;

    ldds_state_s st_q;
    ldds_state_s st_d;
    logic        clr;
    logic        usr;
    logic        sync_fall;
    logic        sync_rise;
    logic        sync_align;
    logic        phase_rst;
    logic        advance;
    logic        locked;
    logic [3:0]  fault_rise;
    logic [15:0] det;
    logic [15:0] ind;
    logic [2:0]  sys0;
    logic [3:0]  sys1;

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == CNT_MAX) ? v : v + 16'h0001;
    endfunction : sat_inc

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d            = st_q;
        st_d.align      = 4'h0;
        st_d.meas_start = 1'b0;
        st_d.rdata      = 16'h0000;
        clr        = WR && (ADDR == A_CMD) && WDATA[CMD_CLR_BIT];
        usr        = WR && (ADDR == A_CMD) && WDATA[CMD_ALIGN_BIT];
        sync_fall  = st_q.sync_prev & ~SYNC_I;
        sync_rise  = ~st_q.sync_prev & SYNC_I;
        sync_align = 1'b0;
        phase_rst  = 1'b0;
        advance    = 1'b0;
        fault_rise = FAULT & ~st_q.fault;
        det        = 16'h0000;
        ind        = 16'h0000;
        st_d.sync_prev = SYNC_I;

        // switches latched once after reset release
        if (!st_q.dip_done) begin
            st_d.dip      = DIP_SW;
            st_d.dip_done = 1'b1;
        end

        // role and hold setting change without any reset
        if (WR && (ADDR == A_CTRL)) begin
            st_d.hold_inf = WDATA[CTRL_HINF_BIT];
            // a synced slave keeps its role
            if (WDATA[CTRL_ROLE_BIT] && !st_q.role && !st_q.synced) begin
                st_d.role    = 1'b1;
                st_d.sy      = SY_MASTER;
                st_d.restart = 32'(RESTART);
            end else if (!WDATA[CTRL_ROLE_BIT] && st_q.role) begin
                st_d.role    = 1'b0;
                st_d.sy      = SY_SLAVE;
                st_d.restart = 32'h0;
            end
        end
        if (WR && (ADDR >= A_THRESH) && (ADDR < A_ALIGN)) begin
            st_d.thresh[ADDR[1:0]] = WDATA;
        end

        // Millisecond clock for the cycle time.
        if (st_q.pre >= 32'(MS_TICKS - 1)) begin
            st_d.pre = 32'h0;
            st_d.ms  = sat_inc(st_q.ms);
        end else begin
            st_d.pre = st_q.pre + 32'h1;
        end
        if (MEAS_DONE) begin
            st_d.busy      = 1'b0;
            st_d.sync_meas = 1'b0;
        end

        // master times the steps, slaves follow the line
        case (st_q.sy)
            SY_MASTER: begin
                if (st_q.restart != 32'h0) begin
                    st_d.restart = st_q.restart - 32'h1;
                    if (st_q.restart == 32'h1) begin
                        phase_rst = 1'b1;
                        st_d.ch   = 2'h3;
                    end
                // line stays low until the slowest is done
                end else if (!st_q.busy && !st_q.meas_start && SYNC_I) begin
                    advance = 1'b1;
                end
            end
            default: begin
                st_d.low_cnt = SYNC_I ? 32'h0 : st_q.low_cnt + 32'h1;
                st_d.silence = sync_fall ? 32'h0 : st_q.silence + 32'h1;
                // realign on sync start and on sync end
                if (sync_rise && st_q.low_cnt >= 32'(RESTART_DET)) begin
                    st_d.synced = 1'b1;
                    sync_align  = 1'b1;
                    phase_rst   = 1'b1;
                    st_d.ch     = 2'h3;
                end else if (st_q.synced &&
                             st_q.silence >= 32'(SILENCE)) begin
                    st_d.synced = 1'b0;
                    sync_align  = 1'b1;
                end else if (st_q.synced) begin
                    advance = sync_fall;
                end else begin
                    advance = !st_q.busy && !st_q.meas_start;
                end
            end
        endcase

        if (advance) begin
            st_d.ch         = st_q.ch + 2'h1;
            st_d.meas_start = 1'b1;
            st_d.busy       = 1'b1;
            st_d.sync_meas  = st_q.synced;
            // cycle time is the span of all four slots
            if (st_q.ch == 2'h3) begin
                st_d.cycle_ms = st_q.ms;
                st_d.ms       = 16'h0;
                st_d.pre      = 32'h0;
            end
        end
        locked = (st_q.sy == SY_MASTER) ? (st_q.restart == 32'h0)
                                        : st_q.synced;
        // A slave pulls only for a slot that the master started. A free-run
        // measurement still running at lock must not pull, or the slave
        // would read its own fall as a master step.
        st_d.sync_oe = (st_q.sy == SY_MASTER) ?
                       ((st_d.restart != 32'h0) || st_d.busy) :
                       (st_d.synced && st_d.sync_meas);

        // 0.5 Hz blink, master phase inverted
        if (phase_rst) begin
            st_d.blink = 32'h0;
            st_d.led   = (st_q.sy != SY_MASTER);
        end else if (!locked) begin
            st_d.blink = 32'h0;
            st_d.led   = RST_LED;
        end else if (st_q.blink >= 32'(BLINK_HALF - 1)) begin
            st_d.blink = 32'h0;
            st_d.led   = ~st_q.led;
        end else begin
            st_d.blink = st_q.blink + 32'h1;
        end

        // clear first, so an event in the same cycle survives
        if (clr) begin
            st_d.align_cnt = '0;
            st_d.hold_cnt  = '0;
            st_d.peak      = '0;
            st_d.cause     = {4{C_OVERRANGE}};
            st_d.rst_cause = 8'h00;
            st_d.rst_cnt   = 16'h0000;
        end
        // bit-coded cause of the latest reset
        if (RST_EVENT) begin
            st_d.rst_cause = RST_CAUSE;
            st_d.rst_cnt   = sat_inc(st_d.rst_cnt);
        end

        for (int i = 0; i < 4; i++) begin
            det = DETUNE[i*16 +: 16];
            st_d.fault[i] = FAULT[i];
            st_d.hist[i]  = st_q.hist[i] | FAULT[i];
            if (det > st_q.thresh[i]) begin
                st_d.occ[i] = 1'b1;
            end else if (det < st_q.thresh[i]) begin
                st_d.occ[i] = 1'b0;
            end
            st_d.align[i] = 1'b1;
            if (OVERRANGE[i]) begin
                st_d.cause[i] = C_OVERRANGE;
            end else if (NORM_BAD[i]) begin
                st_d.cause[i] = C_NORM;
            end else if (fault_rise[i ^ 1]) begin
                st_d.cause[i] = C_PARTNER;
            // infinite hold time blocks hold events
            end else if (HOLD_EV[i] && !st_q.hold_inf) begin
                st_d.cause[i] = C_HOLD;
            end else if (usr) begin
                st_d.cause[i] = C_USER;
            end else if (sync_align) begin
                st_d.cause[i] = C_SYNC;
            end else if (STUCK[i] || STUCK[i ^ 1]) begin
                st_d.cause[i] = C_MUTUAL;
            end else begin
                st_d.align[i] = 1'b0;
            end
            if (st_d.align[i]) begin
                st_d.align_cnt[i] = sat_inc(st_d.align_cnt[i]);
            end
            if (HOLD_EV[i] && !st_q.hold_inf) begin
                st_d.hold_cnt[i] = sat_inc(st_d.hold_cnt[i]);
            end
            if (st_d.align[i]) begin
                st_d.peak[i] = 16'h0000;
            end else if (det > st_d.peak[i]) begin
                st_d.peak[i] = det;
            end
        end

        // zero disables, systems take ascending addresses
        sys0 = st_q.dip[3:1];
        sys1 = (sys0 == 3'h0) ? 4'h0 : {1'b0, sys0} + 4'h1;

        if (RD) begin
            ind = INDUCT[ADDR[1:0]*16 +: 16];
            if (ADDR == A_CTRL) begin
                st_d.rdata = {14'h0, st_q.hold_inf, st_q.role};
            end else if (ADDR == A_STATUS) begin
                st_d.rdata = {2'h0, locked, st_q.role, st_q.hist,
                              st_q.fault, st_q.occ};
            end else if (ADDR == A_RSTCAU) begin
                st_d.rdata = {8'h00, st_q.rst_cause};
            end else if (ADDR == A_RSTCNT) begin
                st_d.rdata = st_q.rst_cnt;
            end else if (ADDR == A_CYCLE) begin
                st_d.rdata = st_q.cycle_ms;
            end else if (ADDR == A_ADDRINF) begin
                st_d.rdata = {6'h0, st_q.dip[0], (sys0 != 3'h0),
                              sys1, 1'b0, sys0};
            end else if (ADDR[5:2] == A_THRESH[5:2]) begin
                st_d.rdata = st_q.thresh[ADDR[1:0]];
            end else if (ADDR[5:2] == A_ALIGN[5:2]) begin
                st_d.rdata = st_q.align_cnt[ADDR[1:0]];
            end else if (ADDR[5:2] == A_HOLD[5:2]) begin
                st_d.rdata = st_q.hold_cnt[ADDR[1:0]];
            end else if (ADDR[5:2] == A_PEAK[5:2]) begin
                st_d.rdata = st_q.peak[ADDR[1:0]];
            end else if (ADDR[5:2] == A_CAUSE[5:2]) begin
                st_d.rdata = {13'h0, st_q.cause[ADDR[1:0]]};
            // rounded down to whole 10 uH steps
            end else if (ADDR[5:2] == A_INDUCT[5:2]) begin
                st_d.rdata = (ind / INDUCT_STEP) * INDUCT_STEP;
            end
        end
        // even parity for each byte of the answer
        st_d.rpar = {^st_d.rdata[15:8], ^st_d.rdata[7:0]};
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q           <= '0;
            st_q.hold_inf  <= RST_HOLD_INF;
            st_q.sy        <= SY_SLAVE;
            st_q.sync_prev <= 1'b1;
            st_q.led       <= RST_LED;
        end else begin
            st_q <= st_d;
        end
    end

    assign RDATA      = st_q.rdata;
    assign RPAR       = st_q.rpar;
    assign MEAS_START = st_q.meas_start;
    assign MEAS_CH    = st_q.ch;
    // The sync line is open drain; only its enable ever moves.
    assign SYNC_O     = st_q.sync_prev & 1'b0;
    assign SYNC_OE    = st_q.sync_oe;
    assign OCC_OUT    = st_q.occ;
    assign ALIGN_REQ  = st_q.align;
    assign LED_FUNC   = st_q.led;
    assign TERM_EN    = st_q.dip[0];

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking dcb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);

    hist_sticky_a: assert property (
        (($past(st_q.hist) & ~st_q.hist) == 4'h0)
    ) else $error("fault history bit dropped");

    hold_frozen_a: assert property (
        st_q.hold_inf && !clr |=> $stable(st_q.hold_cnt)
    ) else $error("hold counter moved with infinite hold");

    occ_on_a: assert property (
        (DETUNE[15:0] > st_q.thresh[0]) |=> OCC_OUT[0]
    ) else $error("channel 0 not occupied above threshold");

    peak_restart_a: assert property (
        ALIGN_REQ[2] |-> (st_q.peak[2] == 16'h0000)
    ) else $error("peak not restarted by alignment");

    partner_align_a: assert property (
        $rose(FAULT[0]) |=> ALIGN_REQ[1]
    ) else $error("partner of faulty channel not aligned");

    pair_align_a: assert property (
        STUCK[3] |=> (ALIGN_REQ[3:2] == 2'b11)
    ) else $error("pair not aligned on supervision failure");

    rst_count_a: assert property (
        RST_EVENT && !clr && (st_q.rst_cnt != CNT_MAX) |=>
            (st_q.rst_cnt == $past(st_q.rst_cnt) + 16'h0001)
    ) else $error("reset count did not step");

    refuse_master_a: assert property (
        st_q.synced && WR && (ADDR == A_CTRL) |=> !st_q.role
    ) else $error("synced slave took master role");

    clear_zero_a: assert property (
        clr && !RST_EVENT |=> (st_q.rst_cnt == 16'h0000) &&
                              (st_q.rst_cause == 8'h00)
    ) else $error("clear left reset data");

    align_sat_a: assert property (
        (st_q.align_cnt[1] == CNT_MAX) && !clr |=>
            (st_q.align_cnt[1] == CNT_MAX)
    ) else $error("alignment counter wrapped");

    read_once_a: assert property (
        !$past(RD) |-> (RDATA == 16'h0000)
    ) else $error("data driven without a read");

endmodule : ldds_top

//--- test/ldds_peer_model.sv
/*
 * Peer detector acting as sync master on the shared sync line.
 * Assumes a pull-up on the line: released means high.
 */
`timescale 1ns/1ns

module ldds_peer_model (
    input  wire logic clk,
    input  wire logic go,
    input  wire logic line,
    output logic      pull
);
    int cnt = 0;

    // restart then steps
    // A long low reads as a master restart; later steps are one-cycle
    // pulls, given only while the line is free so a busy slave delays us.
    always @(posedge clk) begin
        if (!go) begin
            cnt  <= 0;
            pull <= 1'b0;
        end else begin
            cnt  <= cnt + 1;
            pull <= (cnt < 15) || (cnt >= 30 && cnt % 16 == 0 && line);
        end
    end
endmodule : ldds_peer_model

//--- test/ldds_top_tb.sv
/*
 * Self-checking bench of the loop detector diagnostic and sync block.
 * Assumes ldds_pkg, ldds_top and ldds_peer_model are compiled first.
 */
`timescale 1ns/1ns

module ldds_top_tb;
    import ldds_pkg::*;
    logic        CLOCK, SYS_RST, WR, RD, RST_EVENT, MEAS_DONE, SYNC_I;
    logic        MEAS_START, SYNC_O, SYNC_OE, LED_FUNC, TERM_EN, go, pull;
    logic [5:0]  ADDR;
    logic [15:0] WDATA, RDATA, d, t, pk;
    logic [1:0]  RPAR, MEAS_CH, mcnt;
    logic [63:0] DETUNE, INDUCT;
    logic [3:0]  FAULT, OVERRANGE, NORM_BAD, HOLD_EV, STUCK, DIP_SW;
    logic [3:0]  OCC_OUT, ALIGN_REQ;
    logic [7:0]  RST_CAUSE;
    int          n_fail, check_count, seed, i;

    assign SYNC_I = ~(pull | SYNC_OE);

    ldds_top #(.BLINK_HALF(20), .SILENCE(200), .RESTART(20),
               .RESTART_DET(10), .MS_TICKS(10)) dut (
        .CLOCK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .RPAR,
        .DETUNE, .INDUCT, .FAULT, .OVERRANGE, .NORM_BAD, .HOLD_EV,
        .STUCK, .RST_EVENT, .RST_CAUSE, .DIP_SW, .MEAS_DONE,
        .MEAS_START, .MEAS_CH, .SYNC_I, .SYNC_O, .SYNC_OE, .OCC_OUT,
        .ALIGN_REQ, .LED_FUNC, .TERM_EN);
    ldds_peer_model peer (.clk(CLOCK), .go, .line(SYNC_I), .pull);

    // Measurement engine stand-in: every channel takes three cycles.
    // cycle kept short
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            MEAS_DONE <= 1'b0;
            mcnt      <= 2'h0;
        end else begin
            MEAS_DONE <= (mcnt == 2'h1);
            mcnt <= MEAS_START ? 2'h3 : (mcnt != 2'h0 ? mcnt - 2'h1 : 2'h0);
        end
    end

    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    initial begin
        #1000000;
        n_fail++;
        summarize();
    end

    // ************************************************************
    // Bus cycles, comparison and expectations
    // ************************************************************
    function automatic logic [15:0] ind_exp(input logic [15:0] v);
        return v - v % INDUCT_STEP;
    endfunction : ind_exp

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        @(posedge CLOCK);
        {ADDR, WDATA, WR} <= {a, v, 1'b1};
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge CLOCK);
        {ADDR, RD} <= {a, 1'b1};
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        chk(RDATA, e);
        chk({14'h0, RPAR}, {14'h0, ^e[15:8], ^e[7:0]});
    endtask : rd

    task automatic ev(input int k, input logic [3:0] m);
        @(posedge CLOCK);
        case (k)
            0: OVERRANGE <= m;
            1: NORM_BAD <= m;
            2: HOLD_EV <= m;
            default: STUCK <= m;
        endcase
        @(posedge CLOCK);
        {OVERRANGE, NORM_BAD, HOLD_EV, STUCK} <= 16'h0000;
    endtask : ev

    task automatic wt(input int lim, input bit st);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge CLOCK) #1;
            if (st ? MEAS_START === 1'b1 : ALIGN_REQ === 4'hF)
                break;
        end
        if (n == lim) begin
            n_fail++;
            summarize();
        end
    endtask : wt

    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    initial begin
        {SYS_RST, WR, RD, RST_EVENT, go} = 5'b10000;
        {ADDR, WDATA, DETUNE, INDUCT, FAULT, RST_CAUSE} = '0;
        {OVERRANGE, NORM_BAD, HOLD_EV, STUCK} = 16'h0000;
        {DIP_SW, seed, n_fail, check_count, pk} = {4'h5, 32'd12, 64'd0, 16'd0};
        repeat (10) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        rd(A_CTRL, 16'h0002);
        rd(A_ADDRINF, 16'h0332);
        chk({15'h0, TERM_EN}, 16'h0001);
        chk({15'h0, LED_FUNC}, 16'h0001);
        ev(2, 4'h4);
        rd(A_HOLD + 6'h2, 16'h0000);
        wr(A_CTRL, 16'h0000);
        wr(A_CMD, 16'h0001);
        ev(2, 4'h4);
        rd(A_HOLD + 6'h2, 16'h0001);
        rd(A_ALIGN + 6'h2, 16'h0001);
        rd(A_CAUSE + 6'h2, 16'h0003);
        ev(1, 4'h8);
        rd(A_CAUSE + 6'h3, 16'h0001);
        ev(0, 4'h8);
        rd(A_CAUSE + 6'h3, 16'h0000);
        ev(3, 4'h8);
        rd(A_CAUSE + 6'h2, 16'h0006);
        @(posedge CLOCK);
        FAULT <= 4'h1;
        @(posedge CLOCK) #1;
        chk({15'h0, ALIGN_REQ[1]}, 16'h0001);
        rd(A_CAUSE + 6'h1, 16'h0002);
        @(posedge CLOCK);
        FAULT <= 4'h0;
        rd(A_STATUS, 16'h0100);
        @(posedge CLOCK);
        {RST_EVENT, RST_CAUSE} <= 9'h105;
        @(posedge CLOCK);
        RST_EVENT <= 1'b0;
        rd(A_RSTCAU, 16'h0005);
        rd(A_RSTCNT, 16'h0001);
        wr(A_CMD, 16'h0001);
        rd(A_RSTCNT, 16'h0000);
        rd(A_ALIGN + 6'h2, 16'h0000);
        rd(6'h07, 16'h0000);
        // Four free-run slots of six clocks, at ten clocks a millisecond.
        rd(A_CYCLE, 16'h0002);
        for (i = 0; i < 8; i++) begin
            d = 16'($random(seed));
            t = 16'($random(seed));
            wr(A_THRESH, t);
            {DETUNE[15:0], INDUCT[15:0]} <= {d, d};
            rd(A_INDUCT, ind_exp(d));
            chk({15'h0, OCC_OUT[0]}, {15'h0, d > t});
            pk = (d > pk) ? d : pk;
        end
        rd(A_PEAK, pk);
        @(posedge CLOCK);
        DETUNE <= '0;
        wr(A_CMD, 16'h0002);
        rd(A_CAUSE, 16'h0004);
        rd(A_PEAK, 16'h0000);
        @(posedge CLOCK);
        go <= 1'b1;
        wt(100, 1'b0);
        rd(A_STATUS, 16'h2100);
        wr(A_CTRL, 16'h0001);
        rd(A_CTRL, 16'h0000);
        wt(100, 1'b1);
        chk({14'h0, MEAS_CH}, 16'h0000);
        chk({14'h0, SYNC_O, SYNC_OE}, 16'h0001);
        chk({15'h0, LED_FUNC}, 16'h0001);
        repeat (20) @(posedge CLOCK);
        #1;
        chk({15'h0, LED_FUNC}, 16'h0000);
        @(posedge CLOCK);
        go <= 1'b0;
        wt(400, 1'b0);
        rd(A_CAUSE, 16'h0005);
        wr(A_CTRL, 16'h0003);
        rd(A_CTRL, 16'h0003);
        wt(100, 1'b1);
        chk({14'h0, MEAS_CH}, 16'h0000);
        chk({15'h0, LED_FUNC}, 16'h0000);
        rd(A_STATUS, 16'h3100);
        summarize();
    end
endmodule : ldds_top_tb
